// File: umpc_chk.sv
// umpc_chk.sv: pin assertions for umpc_top.
// assumes: bound into umpc_top, one clock.
`timescale 1ns/1ps
`default_nettype none
module umpc_chk
(
	// watched pins
	input wire logic REF_CLK_IN,
	input wire logic RST_IN,
	input wire logic FIFO_DEPTH_SELECT_IN,
	input wire logic INTERRUPT_TRISTATE_SELECT_N_IN,
	input wire logic CHIP_SELECT_HIGH_A_IN,
	input wire logic CHIP_SELECT_HIGH_B_IN,
	input wire logic CHIP_SELECT_LOW_N_IN,
	input wire logic READ_STROBE_HIGH_IN,
	input wire logic READ_STROBE_LOW_N_IN,
	input wire logic WRITE_STROBE_HIGH_IN,
	input wire logic WRITE_STROBE_LOW_N_IN,
	input wire logic USER_OUTPUT_ONE_N_OUT,
	input wire logic USER_OUTPUT_TWO_N_OUT,
	input wire logic [7:0] FIFO_DEPTH_OUT,
	input wire logic HOST_READ_OUT,
	input wire logic HOST_WRITE_OUT,
	input wire logic INTERRUPT_OE_OUT
);
	wire cs = CHIP_SELECT_HIGH_A_IN & CHIP_SELECT_HIGH_B_IN & !CHIP_SELECT_LOW_N_IN;
	wire rq = cs & (READ_STROBE_HIGH_IN | !READ_STROBE_LOW_N_IN);
	wire wq = cs & (WRITE_STROBE_HIGH_IN | !WRITE_STROBE_LOW_N_IN);
	wire idle = USER_OUTPUT_ONE_N_OUT & USER_OUTPUT_TWO_N_OUT;
	default clocking @(posedge REF_CLK_IN); endclocking
	default disable iff (RST_IN);
	a_reset_idle: assert property ($fell(RST_IN) |-> idle)
		else $error("user outputs active after reset");
	a_two_oe: assert property (!USER_OUTPUT_TWO_N_OUT |-> INTERRUPT_OE_OUT)
		else $error("interrupt off with bit set");
	a_strap_oe: assert property (!RST_IN && INTERRUPT_TRISTATE_SELECT_N_IN
		|=> INTERRUPT_OE_OUT)
		else $error("interrupt off with strap high");
	a_pin_deep: assert property (!RST_IN && FIFO_DEPTH_SELECT_IN
		|=> FIFO_DEPTH_OUT == 8'h80)
		else $error("depth not deep");
	a_read_taken: assert property (!RST_IN && rq |=> HOST_READ_OUT)
		else $error("read missed");
	a_write_taken: assert property (!RST_IN && wq |=> HOST_WRITE_OUT)
		else $error("write missed");
	a_read_refused: assert property (!rq |=> !HOST_READ_OUT)
		else $error("read unqualified");
	a_write_refused: assert property (!wq |=> !HOST_WRITE_OUT)
		else $error("write unqualified");
endmodule
bind umpc_top umpc_chk umpc_chk_i (.*);
`default_nettype wire

// File: umpc_consts.vh
// umpc_consts.vh: register offsets, field positions and reset values
// for the miscellaneous pin control block of the serial controller.
// assumes: included by umpc_top.v; definitions only.
`ifndef UMPC_CONSTS_VH
`define UMPC_CONSTS_VH

// axi4-lite byte offsets
`define UMPC_OFF_MODEM_CTRL 5'h00
`define UMPC_OFF_FIFO_CTRL 5'h04
`define UMPC_OFF_LINE_CTRL 5'h08
`define UMPC_OFF_ENH_CTRL 5'h0c
`define UMPC_OFF_PIN_STATUS 5'h10
`define UMPC_OFF_ACCESS_STAT 5'h14

// field positions
`define UMPC_MCR_USER_OUTPUT_ONE_BIT 2
`define UMPC_MCR_USER_OUTPUT_TWO_BIT 3
`define UMPC_MCR_LOOP_BIT 4
`define UMPC_FCR_DEEP_BIT 5
`define UMPC_LCR_GUARD_BIT 7
`define UMPC_ENH_MODE_BIT 0

// reset values
`define UMPC_RST_BYTE 8'h00

// fifo depths
`define UMPC_DEPTH_SHALLOW 8'h10
`define UMPC_DEPTH_DEEP 8'h80

// axi response codes
`define UMPC_RESP_OKAY 2'b00
`define UMPC_RESP_SLVERR 2'b10

`endif

// File: umpc_host_model.sv
// umpc_host_model.sv: host bus side, one strobe style at a time.
// assumes: bench changes requests on rising edges.
`timescale 1ns/1ps
`default_nettype none
module umpc_host_model
(
	// requests
	input wire logic sel_in,
	input wire logic hi_in,
	input wire logic rd_in,
	input wire logic wr_in,
	// bus pins
	output logic cs_a_out,
	output logic cs_b_out,
	output logic cs_n_out,
	output logic rh_out,
	output logic rl_n_out,
	output logic wh_out,
	output logic wl_n_out
);
	assign cs_a_out = sel_in;
	assign cs_b_out = sel_in;
	assign cs_n_out = !sel_in;
	// the unused style is parked inactive
	assign rh_out = hi_in & rd_in;
	assign rl_n_out = !(!hi_in & rd_in);
	assign wh_out = hi_in & wr_in;
	assign wl_n_out = !(!hi_in & wr_in);
endmodule
`default_nettype wire

// File: umpc_top.v
// umpc_top.v: miscellaneous pin control of a single-channel serial
// controller: user outputs, fifo depth selection, host strobe
// qualification and interrupt output enable, with an axi4-lite slave.
// assumes: all inputs synchronous to REF_CLK_IN; the interrupt level
// comes in on INTERRUPT_LEVEL_IN; the loopback source lives in this block's own registers.
// limitation: the interrupt enable drops to 0 while RST_IN is high,
// even with the tri-state select strap high.
// Operation
// (RL1) The first user output pin is the inverse of modem control bit 2.
// (RL2) The second user output pin is the inverse of modem control bit 3.
// (RL3) Both user outputs stay high after reset and during loopback.
// (RL4) With the depth pin low and no override the fifos are 16 deep.
// (RL5) With the depth pin high the fifos are 128 deep.
// (RL6) Software reads the depth pin level live, without latching.
// (RL7) Writing fifo control bit 5 while line control bit 7 is set forces 128 deep.
// (RL8) Enhanced mode also forces 128 deep regardless of the depth pin.
// (RL9) A host access is taken only with all three chip selects active.
// (RL10) Reads are taken on either the high or the low read strobe.
// (RL11) Writes are taken on either the high or the low write strobe.
// (RL12) With the tri-state select pin high the interrupt is always driven.
// (RL13) With the select pin low the interrupt is driven only when modem bit 3 is set.
`timescale 1ns/1ps
`default_nettype none
`include "umpc_consts.vh"

module umpc_top
#(
	// depth codes shown on FIFO_DEPTH_OUT
	parameter [7:0] SHALLOW_DEPTH = `UMPC_DEPTH_SHALLOW,
	parameter [7:0] DEEP_DEPTH = `UMPC_DEPTH_DEEP
)
(
	// clock and reset
	input wire REF_CLK_IN,
	input wire RST_IN,
	// axi4-lite write address and data
	input wire [4:0] S_AXI_AWADDR_IN,
	input wire S_AXI_AWVALID_IN,
	output reg S_AXI_AWREADY_OUT,
	input wire [31:0] S_AXI_WDATA_IN,
	input wire [3:0] S_AXI_WSTRB_IN,
	input wire S_AXI_WVALID_IN,
	output reg S_AXI_WREADY_OUT,
	// axi4-lite write response
	output reg [1:0] S_AXI_BRESP_OUT,
	output reg S_AXI_BVALID_OUT,
	input wire S_AXI_BREADY_IN,
	// axi4-lite read
	input wire [4:0] S_AXI_ARADDR_IN,
	input wire S_AXI_ARVALID_IN,
	output reg S_AXI_ARREADY_OUT,
	output reg [31:0] S_AXI_RDATA_OUT,
	output reg [1:0] S_AXI_RRESP_OUT,
	output reg S_AXI_RVALID_OUT,
	input wire S_AXI_RREADY_IN,
	// board straps and host bus pins
	input wire FIFO_DEPTH_SELECT_IN,
	input wire INTERRUPT_TRISTATE_SELECT_N_IN,
	input wire CHIP_SELECT_HIGH_A_IN,
	input wire CHIP_SELECT_HIGH_B_IN,
	input wire CHIP_SELECT_LOW_N_IN,
	input wire READ_STROBE_HIGH_IN,
	input wire READ_STROBE_LOW_N_IN,
	input wire WRITE_STROBE_HIGH_IN,
	input wire WRITE_STROBE_LOW_N_IN,
	// interrupt source level from the channel
	input wire INTERRUPT_LEVEL_IN,
	// outputs
	output reg USER_OUTPUT_ONE_N_OUT,
	output reg USER_OUTPUT_TWO_N_OUT,
	output reg [7:0] FIFO_DEPTH_OUT,
	output reg HOST_READ_OUT,
	output reg HOST_WRITE_OUT,
	output reg INTERRUPT_OUT,
	output reg INTERRUPT_OE_OUT
);

	reg [7:0] modem_control_reg;
	reg [7:0] fifo_control_reg;
	reg [7:0] line_control_reg;
	reg enhanced_mode;
	reg deep_forced;
	reg [15:0] read_count;
	reg [15:0] write_count;

	// write channel holding
	reg aw_held;
	reg w_held;
	reg [4:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;

	wire loopback = modem_control_reg[`UMPC_MCR_LOOP_BIT];
	wire chip_selected;
	wire read_strobe;
	wire write_strobe;
	wire do_write;
	wire depth_override;
	wire host_read_rise;
	wire host_write_rise;
	wire [1:0] next_user_n;
	genvar pin_idx;
	reg [7:0] next_depth;
	reg [31:0] next_rdata;
	reg next_rerr;

	// all three selects must agree, otherwise strobes are ignored
	assign chip_selected = CHIP_SELECT_HIGH_A_IN & CHIP_SELECT_HIGH_B_IN
		& ~CHIP_SELECT_LOW_N_IN; // [RL9]
	assign read_strobe = READ_STROBE_HIGH_IN | ~READ_STROBE_LOW_N_IN; // [RL10]
	assign write_strobe = WRITE_STROBE_HIGH_IN | ~WRITE_STROBE_LOW_N_IN; // [RL11]
	assign do_write = aw_held & w_held & ~S_AXI_BVALID_OUT;
	// counters see each qualified strobe once, on its leading edge
	assign host_read_rise = chip_selected & read_strobe & ~HOST_READ_OUT;
	assign host_write_rise = chip_selected & write_strobe & ~HOST_WRITE_OUT;
	// a latched guarded write or enhanced mode outranks the strap
	assign depth_override = deep_forced | enhanced_mode; // [RL7] [RL8]

	// one pin per modem bit; the two bits sit next to each other
	generate
		for (pin_idx = 0; pin_idx < 2; pin_idx = pin_idx + 1)
		begin : user_pin
			// loopback parks the pin inactive
			assign next_user_n[pin_idx] = loopback
				| ~modem_control_reg[`UMPC_MCR_USER_OUTPUT_ONE_BIT + pin_idx]; // [RL1] [RL2] [RL3]
		end
	endgenerate

	always @*
	begin
		// pin level is used as-is, override wins
		if (depth_override) // [RL7] [RL8]
			next_depth = DEEP_DEPTH;
		else if (FIFO_DEPTH_SELECT_IN) // [RL5]
			next_depth = DEEP_DEPTH;
		else
			next_depth = SHALLOW_DEPTH; // [RL4]
	end

	always @*
	begin
		next_rdata = 32'h0000_0000;
		next_rerr = 1'b0;
		case (S_AXI_ARADDR_IN)
			`UMPC_OFF_MODEM_CTRL: next_rdata[7:0] = modem_control_reg;
			`UMPC_OFF_FIFO_CTRL: next_rdata[7:0] = fifo_control_reg;
			`UMPC_OFF_LINE_CTRL: next_rdata[7:0] = line_control_reg;
			`UMPC_OFF_ENH_CTRL: next_rdata[0] = enhanced_mode;
			`UMPC_OFF_PIN_STATUS:
			begin
				// live pin, no capture stage in front of it
				next_rdata[0] = FIFO_DEPTH_SELECT_IN; // [RL6]
				next_rdata[1] = INTERRUPT_TRISTATE_SELECT_N_IN;
				next_rdata[15:8] = FIFO_DEPTH_OUT;
			end
			`UMPC_OFF_ACCESS_STAT: next_rdata = {write_count, read_count};
			default: next_rerr = 1'b1;
		endcase
	end

	// write: each ready pulses one cycle after its valid; the register
	// updates and the response rises one cycle after both halves are
	// held; a new address or data beat waits until the held pair is spent,
	// and the next register update waits until the response has been taken
	// write address / data / response
	always @(posedge REF_CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 5'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			S_AXI_AWREADY_OUT <= 1'b0;
			S_AXI_WREADY_OUT <= 1'b0;
			S_AXI_BVALID_OUT <= 1'b0;
			S_AXI_BRESP_OUT <= `UMPC_RESP_OKAY;
			modem_control_reg <= `UMPC_RST_BYTE;
			fifo_control_reg <= `UMPC_RST_BYTE;
			line_control_reg <= `UMPC_RST_BYTE;
			enhanced_mode <= 1'b0;
			deep_forced <= 1'b0;
		end
		else
		begin
			S_AXI_AWREADY_OUT <= ~aw_held & ~S_AXI_AWREADY_OUT & S_AXI_AWVALID_IN;
			S_AXI_WREADY_OUT <= ~w_held & ~S_AXI_WREADY_OUT & S_AXI_WVALID_IN;
			if (S_AXI_AWVALID_IN & S_AXI_AWREADY_OUT)
			begin
				aw_held <= 1'b1;
				aw_addr <= S_AXI_AWADDR_IN;
			end
			if (S_AXI_WVALID_IN & S_AXI_WREADY_OUT)
			begin
				w_held <= 1'b1;
				w_data <= S_AXI_WDATA_IN;
				w_strb <= S_AXI_WSTRB_IN;
			end
			if (S_AXI_BVALID_OUT & S_AXI_BREADY_IN)
				S_AXI_BVALID_OUT <= 1'b0;
			if (do_write)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				S_AXI_BVALID_OUT <= 1'b1;
				S_AXI_BRESP_OUT <= `UMPC_RESP_OKAY;
				// only byte lane 0 carries register bits
				case (aw_addr)
					`UMPC_OFF_MODEM_CTRL:
						if (w_strb[0])
							modem_control_reg <= w_data[7:0];
					`UMPC_OFF_FIFO_CTRL:
						if (w_strb[0])
						begin
							fifo_control_reg <= w_data[7:0];
							// bit 5 only counts behind the line control guard
							if (line_control_reg[`UMPC_LCR_GUARD_BIT])
								deep_forced <= w_data[`UMPC_FCR_DEEP_BIT]; // [RL7]
						end
					`UMPC_OFF_LINE_CTRL:
						if (w_strb[0])
							line_control_reg <= w_data[7:0];
					`UMPC_OFF_ENH_CTRL:
						if (w_strb[0])
							enhanced_mode <= w_data[`UMPC_ENH_MODE_BIT]; // [RL8]
					// status words are read-only; writes are answered okay
					`UMPC_OFF_PIN_STATUS, `UMPC_OFF_ACCESS_STAT: ;
					// unmapped writes answer slverr and change nothing
					default: S_AXI_BRESP_OUT <= `UMPC_RESP_SLVERR;
				endcase
			end
		end
	end

	// data is captured at the address handshake, so a pin read back is
	// its level one cycle before the response rises
	// read channel
	always @(posedge REF_CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			S_AXI_ARREADY_OUT <= 1'b0;
			S_AXI_RVALID_OUT <= 1'b0;
			S_AXI_RDATA_OUT <= 32'h0000_0000;
			S_AXI_RRESP_OUT <= `UMPC_RESP_OKAY;
		end
		else
		begin
			S_AXI_ARREADY_OUT <= ~S_AXI_ARREADY_OUT & ~S_AXI_RVALID_OUT & S_AXI_ARVALID_IN;
			if (S_AXI_ARVALID_IN & S_AXI_ARREADY_OUT)
			begin
				S_AXI_RVALID_OUT <= 1'b1;
				S_AXI_RDATA_OUT <= next_rdata;
				S_AXI_RRESP_OUT <= next_rerr ? `UMPC_RESP_SLVERR : `UMPC_RESP_OKAY;
			end
			else if (S_AXI_RVALID_OUT & S_AXI_RREADY_IN)
				S_AXI_RVALID_OUT <= 1'b0;
		end
	end

	// pins and host strobes
	always @(posedge REF_CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			USER_OUTPUT_ONE_N_OUT <= 1'b1; // [RL3]
			USER_OUTPUT_TWO_N_OUT <= 1'b1; // [RL3]
			FIFO_DEPTH_OUT <= SHALLOW_DEPTH;
			HOST_READ_OUT <= 1'b0;
			HOST_WRITE_OUT <= 1'b0;
			INTERRUPT_OUT <= 1'b0;
			INTERRUPT_OE_OUT <= 1'b0;
		end
		else
		begin
			USER_OUTPUT_ONE_N_OUT <= next_user_n[0]; // [RL1] [RL3]
			USER_OUTPUT_TWO_N_OUT <= next_user_n[1]; // [RL2] [RL3]
			FIFO_DEPTH_OUT <= next_depth;
			HOST_READ_OUT <= chip_selected & read_strobe; // [RL9] [RL10]
			HOST_WRITE_OUT <= chip_selected & write_strobe; // [RL9] [RL11]
			INTERRUPT_OUT <= INTERRUPT_LEVEL_IN;
			// select high: always driven; low: follows modem bit 3
			INTERRUPT_OE_OUT <= INTERRUPT_TRISTATE_SELECT_N_IN // [RL12]
				| modem_control_reg[`UMPC_MCR_USER_OUTPUT_TWO_BIT]; // [RL13]
		end
	end

	// access counters for software; they wrap silently at 16 bits
	always @(posedge REF_CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			read_count <= 16'h0000;
			write_count <= 16'h0000;
		end
		else
		begin
			if (host_read_rise)
				read_count <= read_count + 16'h0001;
			if (host_write_rise)
				write_count <= write_count + 16'h0001;
		end
	end

endmodule
`default_nettype wire

// File: umpc_top_test.sv
// umpc_top_test.sv: bench for umpc_top.
// assumes: umpc_host_model drives the host bus.
`timescale 1ns/1ps
`default_nettype none
`include "umpc_consts.vh"
module umpc_top_test;
	logic c = 0, r = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, pin = 0, ts = 0, lv = 0;
	logic sel = 0, hi = 0, rd = 0, wr = 0;
	logic [4:0] aa = 0, ra = 0;
	logic [31:0] wd = 0, rv;
	logic [1:0] rs, rp;
	wire awr, wrd, bv, arr, rvl, o1, o2, qr, qw, io, oe, ca, cb, cn, rh, rl, wh, wl;
	wire [1:0] br, rr;
	wire [31:0] rdat;
	wire [7:0] dep;
	integer fails = 0, tests_run = 0, cyc = 0, i;
	umpc_host_model umpc_host_model_i (.sel_in(sel), .hi_in(hi), .rd_in(rd), .wr_in(wr),
		.cs_a_out(ca), .cs_b_out(cb), .cs_n_out(cn), .rh_out(rh), .rl_n_out(rl),
		.wh_out(wh), .wl_n_out(wl));
	umpc_top umpc_top_i (.REF_CLK_IN(c), .RST_IN(r), .S_AXI_AWADDR_IN(aa),
		.S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd),
		.S_AXI_WSTRB_IN(4'hf), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wrd),
		.S_AXI_BRESP_OUT(br), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(bre),
		.S_AXI_ARADDR_IN(ra), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr),
		.S_AXI_RDATA_OUT(rdat), .S_AXI_RRESP_OUT(rr), .S_AXI_RVALID_OUT(rvl),
		.S_AXI_RREADY_IN(rre), .FIFO_DEPTH_SELECT_IN(pin), .INTERRUPT_TRISTATE_SELECT_N_IN(ts),
		.CHIP_SELECT_HIGH_A_IN(ca), .CHIP_SELECT_HIGH_B_IN(cb), .CHIP_SELECT_LOW_N_IN(cn),
		.READ_STROBE_HIGH_IN(rh), .READ_STROBE_LOW_N_IN(rl), .WRITE_STROBE_HIGH_IN(wh),
		.WRITE_STROBE_LOW_N_IN(wl), .INTERRUPT_LEVEL_IN(lv), .USER_OUTPUT_ONE_N_OUT(o1),
		.USER_OUTPUT_TWO_N_OUT(o2), .FIFO_DEPTH_OUT(dep), .HOST_READ_OUT(qr),
		.HOST_WRITE_OUT(qw), .INTERRUPT_OUT(io), .INTERRUPT_OE_OUT(oe));
	task print_verdict;
		begin
			$display("checks %0d mismatches %0d", tests_run, fails);
			if (fails == 0 && tests_run > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		begin
			tests_run++;
			if (g !== e)
			begin
				fails++;
				$display("mismatch %s exp %h got %h", n, e, g);
			end
		end
	endtask
	task t(input integer n);
		begin
			repeat (n) @(posedge c);
			#1;
		end
	endtask
	// valids drop at their own handshake edge, ready held until the answer
	task wreg(input logic [4:0] a, input logic [31:0] d);
		begin
			@(posedge c);
			aa <= a;
			wd <= d;
			awv <= 1;
			wv <= 1;
			bre <= 1;
			do
			begin
				@(posedge c);
				if (awr) awv <= 0;
				if (wrd) wv <= 0;
			end while (!bv);
			bre <= 0;
			rs = br;
			t(2);
		end
	endtask
	task rreg(input logic [4:0] a);
		begin
			@(posedge c);
			ra <= a;
			arv <= 1;
			rre <= 1;
			do
			begin
				@(posedge c);
				if (arr) arv <= 0;
			end while (!rvl);
			rre <= 0;
			rv = rdat;
			rp = rr;
		end
	endtask
	initial
	begin
		forever #12.5 c = ~c;
	end
	always @(posedge c)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			fails++;
			print_verdict;
		end
	end
	initial
	begin
		repeat (8) @(posedge c);
		r <= 0;
		t(1);
		cmp("user outs", 2'b11, {o1, o2});
		cmp("depth", 8'h10, dep);
		wreg(`UMPC_OFF_MODEM_CTRL, 32'h04);
		cmp("outs bit2", 3'b010, {o1, o2, oe});
		wreg(`UMPC_OFF_MODEM_CTRL, 32'h08);
		cmp("outs bit3", 3'b101, {o1, o2, oe});
		wreg(`UMPC_OFF_MODEM_CTRL, 32'h1c);
		cmp("loopback", 2'b11, {o1, o2});
		wreg(`UMPC_OFF_MODEM_CTRL, 32'h00);
		@(posedge c);
		ts <= 1;
		lv <= 1;
		t(2);
		cmp("int enabled", 2'b11, {oe, io});
		@(posedge c);
		lv <= 0;
		t(2);
		cmp("int still on", 2'b10, {oe, io});
		$display("test pins done");
		@(posedge c);
		pin <= 1;
		rreg(`UMPC_OFF_PIN_STATUS);
		cmp("pin live", 1'b1, rv[0]);
		cmp("pin rresp", `UMPC_RESP_OKAY, rp);
		cmp("depth", 8'h80, dep);
		@(posedge c);
		pin <= 0;
		wreg(`UMPC_OFF_FIFO_CTRL, 32'h20);
		cmp("unguarded", 8'h10, dep);
		wreg(`UMPC_OFF_LINE_CTRL, 32'h80);
		wreg(`UMPC_OFF_FIFO_CTRL, 32'h20);
		cmp("guarded", 8'h80, dep);
		wreg(`UMPC_OFF_FIFO_CTRL, 32'h00);
		wreg(`UMPC_OFF_ENH_CTRL, 32'h01);
		cmp("enhanced", 8'h80, dep);
		wreg(5'h18, 32'h01);
		cmp("unmapped", `UMPC_RESP_SLVERR, rs);
		rreg(5'h1c);
		cmp("unmapped rresp", `UMPC_RESP_SLVERR, rp);
		cmp("unmapped rdata", 32'h0, rv);
		rreg(`UMPC_OFF_PIN_STATUS);
		cmp("pin status", 32'h0000_8002, rv);
		$display("test depth done");
		wreg(`UMPC_OFF_MODEM_CTRL, 32'h0c);
		cmp("both low", 2'b00, {o1, o2});
		@(posedge c);
		r <= 1;
		t(2);
		cmp("outs in reset", 2'b11, {o1, o2});
		@(posedge c);
		r <= 0;
		t(1);
		cmp("outs released", 2'b11, {o1, o2});
		cmp("depth released", 8'h10, dep);
		rreg(`UMPC_OFF_MODEM_CTRL);
		cmp("modem cleared", 32'h0, rv);
		$display("test reset done");
		// bit2 selects, bit1 write, bit0 high-true strobe style
		for (i = 0; i < 8; i++)
		begin
			@(posedge c);
			sel <= i[2];
			hi <= i[0];
			rd <= !i[1];
			wr <= i[1];
			t(2);
			cmp("host read", i[2] & !i[1], qr);
			cmp("host write", i[2] & i[1], qw);
		end
		rreg(`UMPC_OFF_ACCESS_STAT);
		cmp("access counts", 32'h0001_0001, rv);
		$display("test host done");
		print_verdict;
	end
endmodule
`default_nettype wire
